/* File: hdl/port2_flow_defines.vh */
`ifndef PORT2_FLOW_DEFINES_VH
`define PORT2_FLOW_DEFINES_VH
// ****************************************
// Register map (word offsets, byte address = 4 * index)
// ****************************************
`define FC_ADDR_W        4
`define FC_CTRL_IDX      4'h0
`define FC_STAT_IDX      4'h1
`define FC_LOAD_IDX      4'h2
// ****************************************
// Control register fields
// ****************************************
`define FC_BIT_MANUAL    0
`define FC_BIT_TXEN      1
`define FC_BIT_RXEN      2
`define FC_BIT_CURTX     3
`define FC_BIT_CURRX     4
`define FC_BIT_CURDUP    5
`define FC_BIT_BPEN      6
// ****************************************
// Loader register fields (emulated loader rewrite)
// ****************************************
`define LD_BIT_BP        0
`define LD_BIT_FD        1
`define LD_BIT_MAN       2
`define FC_DATA_ZERO     32'h0000_0000
`endif

/* File: hdl/sync_bit.v */
`default_nettype none
// ****************************************
// Two-stage reset release
// ****************************************
module sync_bit (
	input  wire clk,
	input  wire rstn,
	output wire syncOut
);
	reg stage1Q;
	reg stage2Q;

	// Asynchronous assert, synchronous release
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage1Q <= 1'b0;
			stage2Q <= 1'b0;
		end else begin
			stage1Q <= 1'b1;
			stage2Q <= stage1Q;
		end
	end

	assign syncOut = stage2Q;
endmodule // sync_bit
`default_nettype wire

/* File: hdl/port2_flow_control_select.v */
// Operation
// - Select 0 with negotiation on takes flow control from the negotiated result.
// - Select 0 with negotiation off uses the manual receive and transmit enables.
// - Select 1 always uses the manual receive and transmit enables.
// - Under manual control the receive enable gates Pause frame detection.
// - Under manual control the transmit enable gates Pause frame generation.
// - A readable bit shows whether transmit flow control is active.
// - Backpressure, manual enables and select reset to their strap inputs.
// - A loader rewrite of a strap updates the matching field.
// - The current-status reset value derives from several straps.
`include "port2_flow_defines.vh"
`default_nettype none
module port2_flow_control_select (
	input  wire        clk,
	input  wire        rstn,
	input  wire        clkEn,
	// Avalon-MM slave
	input  wire [3:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	// Straps and negotiation
	input  wire        backpressureDefaultStrap,
	input  wire        fullDuplexFlowDefaultStrap,
	input  wire        manualSelectDefaultStrap,
	input  wire        autoNegEnable,
	input  wire        autoNegDone,
	input  wire        anRxPause,
	input  wire        anTxPause,
	input  wire        halfDuplex,
	// Effective enables toward the MAC
	output reg         rxPauseDetectEnable,
	output reg         txPauseGenerateEnable,
	output reg         backpressureEnable
);
	// ****************************************
	// Reset release
	// ****************************************
	wire rstnSync;

	sync_bit resetSync (
		.clk     (clk),
		.rstn    (rstn),
		.syncOut (rstnSync)
	);

	// ****************************************
	// Strap capture state machine
	// ****************************************
	localparam [1:0] ST_CAPTURE = 2'b01;
	localparam [1:0] ST_RUN     = 2'b10;

	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg         manualFlowSelect_q;
	reg         rxEnable_q;
	reg         txEnable_q;
	reg         bpEnable_q;
	reg         ackPending_q;
	reg         manualFlowSelect_d;
	reg         rxEnable_d;
	reg         txEnable_d;
	reg         bpEnable_d;
	reg         ackPending_d;
	reg  [31:0] readWord;
	wire        capture;
	wire        busReq;
	wire        busDone;
	wire        lowLane;
	wire        ctrlWrite;
	wire        loadWrite;
	wire        readStart;
	wire        manualMode;
	wire        effRx;
	wire        effTx;

	// Capture state is the only cycle that samples the straps
	assign capture = state_q[0];

	// Straps are taken on the first enabled clock after reset release
	always @* begin
		case (state_q)
			ST_CAPTURE: state_d = ST_RUN;
			ST_RUN:     state_d = ST_RUN;
			default:    state_d = ST_CAPTURE;
		endcase
	end

	// ****************************************
	// Bus decode
	// ****************************************
	// A request is live while read or write is held by the master
	assign busReq    = read || write;
	// Second cycle of a request; a frozen clock never completes one
	assign busDone   = busReq && ackPending_q && clkEn;
	// Only the low byte lane carries fields; other lanes are ignored
	assign lowLane   = byteenable[0];
	assign ctrlWrite = write && busDone && lowLane && (address == `FC_CTRL_IDX);
	assign loadWrite = write && busDone && lowLane && (address == `FC_LOAD_IDX);
	// Read data are latched in the wait cycle and stand at completion
	assign readStart = read && !ackPending_q;

	// ****************************************
	// Field next values
	// ****************************************
	// Strap capture outranks any bus write landing in the same cycle
	// Loader rewrite shares the capture path so both fill fields alike
	always @* begin
		manualFlowSelect_d = manualFlowSelect_q;
		rxEnable_d         = rxEnable_q;
		txEnable_d         = txEnable_q;
		bpEnable_d         = bpEnable_q;
		if (capture) begin
			bpEnable_d         = backpressureDefaultStrap;
			rxEnable_d         = fullDuplexFlowDefaultStrap;
			txEnable_d         = fullDuplexFlowDefaultStrap;
			manualFlowSelect_d = manualSelectDefaultStrap;
		end else if (loadWrite) begin
			bpEnable_d         = writedata[`LD_BIT_BP];
			rxEnable_d         = writedata[`LD_BIT_FD];
			txEnable_d         = writedata[`LD_BIT_FD];
			manualFlowSelect_d = writedata[`LD_BIT_MAN];
		end else if (ctrlWrite) begin
			bpEnable_d         = writedata[`FC_BIT_BPEN];
			rxEnable_d         = writedata[`FC_BIT_RXEN];
			txEnable_d         = writedata[`FC_BIT_TXEN];
			manualFlowSelect_d = writedata[`FC_BIT_MANUAL];
		end
	end

	// ****************************************
	// Control fields
	// ****************************************
	// Async reset loads constants only; strap values arrive one cycle later
	always @(posedge clk or negedge rstnSync) begin
		if (!rstnSync) begin
			state_q            <= ST_CAPTURE;
			manualFlowSelect_q <= 1'b0;
			rxEnable_q         <= 1'b0;
			txEnable_q         <= 1'b0;
			bpEnable_q         <= 1'b0;
		end else if (clkEn) begin
			state_q            <= state_d;
			manualFlowSelect_q <= manualFlowSelect_d;
			rxEnable_q         <= rxEnable_d;
			txEnable_q         <= txEnable_d;
			bpEnable_q         <= bpEnable_d;
		end
	end

	// ****************************************
	// Flow control resolution
	// ****************************************
	// Manual when selected, or when negotiation is off
	assign manualMode = manualFlowSelect_q || !autoNegEnable;
	// Before negotiation completes, no Pause is honoured in auto mode
	assign effRx = manualMode ? rxEnable_q : (autoNegDone && anRxPause);
	assign effTx = manualMode ? txEnable_q : (autoNegDone && anTxPause);

	// Registered effective enables; status derives from straps via these
	// One edge of lag is the price of glitch-free enables toward the MAC
	always @(posedge clk or negedge rstnSync) begin
		if (!rstnSync) begin
			rxPauseDetectEnable   <= 1'b0;
			txPauseGenerateEnable <= 1'b0;
			backpressureEnable    <= 1'b0;
		end else if (clkEn) begin
			rxPauseDetectEnable   <= effRx;
			txPauseGenerateEnable <= effTx;
			backpressureEnable    <= bpEnable_q;
		end
	end

	// ****************************************
	// Readback word
	// ****************************************
	// Status index mirrors control so polling needs no decode of its own
	always @* begin
		readWord = `FC_DATA_ZERO;
		case (address)
			`FC_CTRL_IDX, `FC_STAT_IDX: begin
				readWord[`FC_BIT_MANUAL] = manualFlowSelect_q;
				readWord[`FC_BIT_TXEN]   = txEnable_q;
				readWord[`FC_BIT_RXEN]   = rxEnable_q;
				readWord[`FC_BIT_CURTX]  = txPauseGenerateEnable;
				readWord[`FC_BIT_CURRX]  = rxPauseDetectEnable;
				readWord[`FC_BIT_CURDUP] = halfDuplex;
				readWord[`FC_BIT_BPEN]   = bpEnable_q;
			end
			// Loader index is write only; unmapped indexes read zero
			default: readWord = `FC_DATA_ZERO;
		endcase
	end

	// ****************************************
	// Avalon-MM slave: one wait state per access
	// ****************************************
	// Frozen clock holds the master in wait, so no access is half done
	assign waitrequest = busReq && (!ackPending_q || !clkEn);

	// Wait flag toggles once per request; back-to-back accesses cost two cycles each
	always @* begin
		ackPending_d = 1'b0;
		if (busReq && !ackPending_q) begin
			ackPending_d = 1'b1;
		end
	end

	// Read data latch in the wait cycle and stand until the next read
	always @(posedge clk or negedge rstnSync) begin
		if (!rstnSync) begin
			ackPending_q <= 1'b0;
			readdata     <= `FC_DATA_ZERO;
		end else if (clkEn) begin
			ackPending_q <= ackPending_d;
			if (readStart) begin
				readdata <= readWord;
			end
		end
	end
endmodule // port2_flow_control_select
`default_nettype wire

/* File: tb/port2_flow_checker.sv */
`default_nettype none
module port2_flow_checker (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [3:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        autoNegEnable,
	input wire logic        autoNegDone,
	input wire logic        anRxPause,
	input wire logic        anTxPause,
	input wire logic        rxPauseDetectEnable,
	input wire logic        txPauseGenerateEnable,
	input wire logic        backpressureEnable
);
	// ***
	// Bus and mirror checks
	// ***
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Read completing at the control word
	wire logic ctlRd = read && !waitrequest && address == 4'h0;
	a_wait_first: assert property ($rose(read | write) |-> waitrequest) else $error("no wait state");
	a_wait_one: assert property ((read | write) && waitrequest |=> !waitrequest)
		else $error("wait state too long");
	a_cur_status: assert property (ctlRd |->
		readdata[4:3] == {rxPauseDetectEnable, txPauseGenerateEnable})
		else $error("current bits differ");
	a_bp_mirror: assert property (ctlRd |-> readdata[6] == backpressureEnable)
		else $error("backpressure bit differs");
	a_reserved_zero: assert property (ctlRd |-> readdata[31:7] == 25'h0) else $error("reserved set");
	a_auto_result: assert property (ctlRd && !readdata[0] && autoNegEnable && autoNegDone
		|-> txPauseGenerateEnable == anTxPause && rxPauseDetectEnable == anRxPause)
		else $error("auto result ignored");
	a_manual_bits: assert property (ctlRd &&
		(readdata[0] || !autoNegEnable)
		|-> txPauseGenerateEnable == readdata[1] && rxPauseDetectEnable == readdata[2])
		else $error("manual bits ignored");
	a_unmapped_zero: assert property (read && !waitrequest && address == 4'h3 |-> readdata == 32'h0)
		else $error("unmapped read not zero");
endmodule // port2_flow_checker
bind port2_flow_control_select port2_flow_checker i_chk (.clk, .rstn, .address, .read, .write,
	.readdata, .waitrequest, .autoNegEnable, .autoNegDone, .anRxPause, .anTxPause,
	.rxPauseDetectEnable, .txPauseGenerateEnable, .backpressureEnable);
`default_nettype wire

/* File: tb/port2_flow_control_select_tb_top.sv */
`default_nettype none
module port2_flow_control_select_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rstn = 0, read = 0, write = 0, anEn = 0, anRx = 1, anTx = 0;
	logic        anDone = 1, hDup = 1;
	logic [3:0]  address = 4'h0;
	logic [31:0] writedata = 32'h0, readdata;
	wire logic   waitrequest, rxE, txE, bpE;
	int          err_count = 0, n_tests = 0;
	// ***
	// Device and clock
	// ***
	port2_flow_control_select i_dut (.clk, .rstn, .clkEn(1'b1), .address, .read, .write,
		.writedata, .byteenable(4'hf), .readdata, .waitrequest, .backpressureDefaultStrap(1'b1),
		.fullDuplexFlowDefaultStrap(1'b1), .manualSelectDefaultStrap(1'b1), .autoNegEnable(anEn),
		.autoNegDone(anDone), .anRxPause(anRx), .anTxPause(anTx), .halfDuplex(hDup),
		.rxPauseDetectEnable(rxE), .txPauseGenerateEnable(txE), .backpressureEnable(bpE));
	initial forever #50 clk = ~clk;
	task chk(string what, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Request held until the edge that sees waitrequest low
	task bus(logic wr, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 0;
		write <= 0;
	endtask
	// Outputs lag their cause by one edge; three leaves margin
	task settle;
		repeat (3) @(negedge clk);
	endtask
	task t_strap;
		logic [31:0] q;
		bus(0, 4'h0, 0, q);
		chk("ctrl", q, 32'h7f);
		chk("outs", {rxE, txE, bpE}, 3'b111);
		$display("strap test done");
	endtask
	task t_modes;
		logic [31:0] q;
		logic [1:0]  e;
		for (int m = 0; m < 4; m++) begin
			@(posedge clk) anEn <= m[0];
			bus(1, 4'h0, {30'h0, 1'b1, m[1]}, q);
			settle;
			bus(0, 4'h0, 0, q);
			e = (m == 1) ? 2'b10 : 2'b01;
			chk("rxtx", {rxE, txE}, e);
			chk("cur", q[4:3], e);
		end
		// Auto mode, manual enables cleared: done gates, then tx comes from negotiation
		@(posedge clk);
		anDone <= 0;
		bus(1, 4'h0, 32'h0, q);
		settle;
		bus(0, 4'h0, 0, q);
		chk("undone", {rxE, txE}, 2'b00);
		@(posedge clk);
		anDone <= 1;
		anRx <= 0;
		anTx <= 1;
		settle;
		bus(0, 4'h0, 0, q);
		chk("auto", {rxE, txE}, 2'b01);
		chk("autocur", q[4:3], 2'b01);
		$display("mode test done");
	endtask
	task t_loader;
		logic [31:0] q;
		@(posedge clk);
		hDup <= 0;
		bus(1, 4'h2, 32'h4, q);
		settle;
		bus(0, 4'h0, 0, q);
		chk("load", q, 32'h01);
		chk("lout", {rxE, txE, bpE}, 3'b000);
		bus(0, 4'h3, 0, q);
		chk("unmapped", q, 32'h0);
		bus(0, 4'h1, 0, q);
		chk("mirror", q, 32'h01);
		$display("loader test done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Whole run is near 75 cycles; the limit is far beyond it
	initial begin
		#100000;
		err_count++;
		final_report;
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1;
		repeat (4) @(posedge clk);
		t_strap;
		t_modes;
		t_loader;
		final_report;
	end
endmodule // port2_flow_control_select_tb_top
`default_nettype wire
